// ==== rtl/gain_mute_pkg.sv ====
// Constants and types shared by the gain and mute control registers
`default_nettype none
package gain_mute_pkg;
  // Register addresses on the control port
  localparam logic [15:0] ADDR_LEFT_REC_ATTEN = 16'h401a;
  localparam logic [15:0] ADDR_RIGHT_REC_ATTEN = 16'h401b;
  localparam logic [15:0] ADDR_LEFT_MIX = 16'h401c;
  localparam logic [15:0] ADDR_RIGHT_MIX = 16'h401e;
  localparam logic [15:0] ADDR_MONO_MIX = 16'h401f;
  localparam logic [15:0] ADDR_CLAMP = 16'h4020;
  localparam logic [15:0] ADDR_LEFT_LINE = 16'h4025;
  localparam logic [15:0] ADDR_RIGHT_LINE = 16'h4026;
  localparam logic [15:0] ADDR_ZC_CTL = 16'h4028;
  // Implemented bits; everything else is reserved
  localparam logic [7:0] MASK_ATTEN = 8'hff;
  localparam logic [7:0] MASK_LEFT_MIX = 8'h3e;
  localparam logic [7:0] MASK_RIGHT_MIX = 8'h5e;
  localparam logic [7:0] MASK_MONO_MIX = 8'hfd;
  localparam logic [7:0] MASK_CLAMP = 8'h03;
  localparam logic [7:0] MASK_LINE = 8'h02;
  localparam logic [7:0] MASK_ZC_CTL = 8'h19;
  // Values after reset
  localparam logic [7:0] RST_ATTEN = 8'h00;
  localparam logic [7:0] RST_MIX = 8'h00;
  localparam logic [7:0] RST_CLAMP = 8'h02;
  localparam logic [7:0] RST_LINE = 8'h00;
  localparam logic [7:0] RST_ZC_CTL = 8'h19;
  // Field positions
  localparam int LEFT_DAC_UNMUTE_BIT = 5;
  localparam int RIGHT_DAC_UNMUTE_BIT = 6;
  localparam int STEREO_BEEP_LSB = 1;
  localparam int MONO_LEFT_UNMUTE_BIT = 7;
  localparam int MONO_RIGHT_UNMUTE_BIT = 6;
  localparam int MONO_BEEP_LSB = 2;
  localparam int MONO_LINE_UNMUTE_BIT = 0;
  localparam int CLAMP_DISABLE_BIT = 0;
  localparam int CLAMP_LOW_POWER_BIT = 1;
  localparam int LINE_UNMUTE_BIT = 1;
  localparam int ZC_ENABLE_BIT = 0;
  localparam int ZC_TIMEOUT_LSB = 3;
  // Beep gain coding
  localparam logic [3:0] BEEP_GAIN_MUTE = 4'h0;
  localparam logic [3:0] BEEP_GAIN_MAX = 4'h8;
  // Zero-crossing timeouts
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_20MS_NS = 20000000;
  localparam int TIMEOUT_10MS_NS = 10000000;
  localparam int TIMEOUT_5MS_NS = 5000000;
  localparam int TIMEOUT_2P5MS_NS = 2500000;
  localparam int TIMEOUT_20MS_CYCLES = TIMEOUT_20MS_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_10MS_CYCLES = TIMEOUT_10MS_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_5MS_CYCLES = TIMEOUT_5MS_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_2P5MS_CYCLES = TIMEOUT_2P5MS_NS / CLK_PERIOD_NS;
  localparam int BEEP_CNT_W = 22;

  typedef enum logic [1:0] {
    BEEP_IDLE = 2'b00,
    BEEP_WAIT = 2'b01
  } beep_state_type;

  // Codes above +6 dB are undefined; hold them at the top step
  function automatic logic [3:0] beep_code_sat(input logic [3:0] code);
    beep_code_sat = (code > BEEP_GAIN_MAX) ? BEEP_GAIN_MAX : code;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/beep_gain_updater.sv ====
// Beep gain holder that applies new gains at a zero crossing or timeout
`default_nettype none
module beep_gain_updater import gain_mute_pkg::*; #(
  parameter int T20_CYC = TIMEOUT_20MS_CYCLES,
  parameter int T10_CYC = TIMEOUT_10MS_CYCLES,
  parameter int T5_CYC = TIMEOUT_5MS_CYCLES,
  parameter int T2P5_CYC = TIMEOUT_2P5MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic zc_pulse,
  input wire logic zc_enable,
  input wire logic [1:0] timeout_sel,
  input wire logic [3:0] target_left,
  input wire logic [3:0] target_right,
  input wire logic [3:0] target_mono,
  output logic [3:0] applied_left,
  output logic [3:0] applied_right,
  output logic [3:0] applied_mono
);
  typedef struct packed {
    beep_state_type state;
    logic [BEEP_CNT_W-1:0] count;
    logic [3:0] left;
    logic [3:0] right;
    logic [3:0] mono;
  } beep_regs_type;

  beep_regs_type st;
  beep_regs_type next_st;
  logic [BEEP_CNT_W-1:0] limit;
  logic [11:0] want;
  logic pending;

  always_comb begin
    case (timeout_sel)
      2'b00: limit = BEEP_CNT_W'(T20_CYC - 1);
      2'b01: limit = BEEP_CNT_W'(T10_CYC - 1);
      2'b10: limit = BEEP_CNT_W'(T5_CYC - 1);
      default: limit = BEEP_CNT_W'(T2P5_CYC - 1);
    endcase
  end

  always_comb begin
    want = {beep_code_sat(target_left), beep_code_sat(target_right),
      beep_code_sat(target_mono)};
    pending = (want != {st.left, st.right, st.mono});
    next_st = st;
    case (st.state)
      BEEP_IDLE: begin
        if (pending) begin
          if (!zc_enable || zc_pulse) begin
            {next_st.left, next_st.right, next_st.mono} = want;
          end else begin
            next_st.state = BEEP_WAIT;
            next_st.count = '0;
          end
        end
      end
      BEEP_WAIT: begin
        // Forced at the crossing or when the timeout runs out
        if (!zc_enable || zc_pulse || st.count >= limit) begin
          {next_st.left, next_st.right, next_st.mono} = want;
          next_st.state = BEEP_IDLE;
          next_st.count = '0;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      default: next_st.state = BEEP_IDLE;
    endcase
    if (!rst_n) begin
      next_st = '0;
      next_st.state = BEEP_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign applied_left = st.left;
  assign applied_right = st.right;
  assign applied_mono = st.mono;

  // Host may shorten the timeout mid-wait, so check the forced exit, not the count
  chk_beep_wait_bound: assert property (@(posedge clk) disable iff (!rst_n)
    (st.state == BEEP_WAIT && st.count >= limit) |=> st.state == BEEP_IDLE)
    else $error("beep wait ran past its timeout");
  chk_beep_change_gated: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(st.left) && $past(zc_enable) && $past(rst_n)) |->
      ($past(zc_pulse) || ($past(st.state) == BEEP_WAIT && $past(st.count) >= $past(limit))))
    else $error("beep gain changed without crossing or timeout");
  chk_beep_zc_apply: assert property (@(posedge clk) disable iff (!rst_n)
    zc_pulse |=> st.mono == beep_code_sat($past(target_mono)))
    else $error("mono beep gain not applied at crossing");
  chk_beep_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    !zc_enable |=> st.left == beep_code_sat($past(target_left)))
    else $error("beep gain waited with detector off");
endmodule // beep_gain_updater
`default_nettype wire

// ==== rtl/codec_gain_mute_control.sv ====
// Record attenuators, playback mutes, beep gains and line output control
// Operation
// - Attenuator code n gives n times 0.375 dB, 0 to -95.625 dB.
// - Applied attenuation steps one code per audio frame toward target.
// - Left record attenuator resets to zero, no attenuation.
// - Playback mixer DAC mutes act at write completion, 0 muted.
// - Stereo beep gains apply at next crossing or timeout.
// - Beep code 0 mutes, 1 to 8 give -15 to +6 dB.
// - Mono mixer bits 7 and 6 mute DACs without powering down.
// - Mono beep gain uses same coding and crossing rule.
// - Mono mixer bit 0 is active-low mono line output mute.
// - Clamp bit 0 low enables the clamp amplifier.
// - Clamp bit 1 selects low power, reset to low power.
// - Line mute bit 1 active low, speaker untouched.
// - Missing crossing forces change after 20, 10, 5 or 2.5 ms.
// - Detector enable, reset on; off applies beep gains at once.
`default_nettype none
module codec_gain_mute_control import gain_mute_pkg::*; #(
  parameter int T20_CYC = TIMEOUT_20MS_CYCLES,
  parameter int T10_CYC = TIMEOUT_10MS_CYCLES,
  parameter int T5_CYC = TIMEOUT_5MS_CYCLES,
  parameter int T2P5_CYC = TIMEOUT_2P5MS_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  input wire logic FRAME_SYNC,
  input wire logic BEEP_ZC,
  output logic [7:0] LEFT_REC_ATTEN,
  output logic [7:0] RIGHT_REC_ATTEN,
  output logic LEFT_DAC_UNMUTE,
  output logic RIGHT_DAC_UNMUTE,
  output logic MONO_LEFT_DAC_UNMUTE,
  output logic MONO_RIGHT_DAC_UNMUTE,
  output logic MONO_LINE_UNMUTE,
  output logic [3:0] LEFT_BEEP_GAIN,
  output logic [3:0] RIGHT_BEEP_GAIN,
  output logic [3:0] MONO_BEEP_GAIN,
  output logic CLAMP_DISABLE,
  output logic CLAMP_LOW_POWER,
  output logic LEFT_LINE_UNMUTE,
  output logic RIGHT_LINE_UNMUTE
);
  typedef struct packed {
    logic [7:0] left_rec_target;
    logic [7:0] right_rec_target;
    logic [7:0] left_rec_applied;
    logic [7:0] right_rec_applied;
    logic [7:0] left_mix;
    logic [7:0] right_mix;
    logic [7:0] mono_mix;
    logic [7:0] clamp;
    logic [7:0] left_line;
    logic [7:0] right_line;
    logic [7:0] zc_ctl;
    logic [7:0] rdata;
    logic [1:0] frame_sync;
    logic frame_prev;
    logic [1:0] zc_sync;
    logic zc_prev;
  } ctl_regs_type;

  ctl_regs_type st;
  ctl_regs_type next_st;
  logic frame_tick;
  logic zc_pulse;

  // One attenuator step toward the target; never overshoots
  function automatic logic [7:0] slew_step(input logic [7:0] applied,
                                           input logic [7:0] target);
    if (applied < target) begin
      slew_step = applied + 8'h01;
    end else if (applied > target) begin
      slew_step = applied - 8'h01;
    end else begin
      slew_step = applied;
    end
  endfunction

  // Write a register keeping only implemented bits
  function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
    masked = data & mask;
  endfunction

  // Edge detectors look only at the second synchroniser stage
  assign frame_tick = st.frame_sync[1] & ~st.frame_prev;
  assign zc_pulse = st.zc_sync[1] & ~st.zc_prev;

  always_comb begin
    next_st = st;
    next_st.frame_sync = {st.frame_sync[0], FRAME_SYNC};
    next_st.frame_prev = st.frame_sync[1];
    next_st.zc_sync = {st.zc_sync[0], BEEP_ZC};
    next_st.zc_prev = st.zc_sync[1];

    // Codes map linearly in dB, so the ramp is logarithmic in level
    if (frame_tick) begin
      next_st.left_rec_applied = slew_step(st.left_rec_applied, st.left_rec_target);
      next_st.right_rec_applied = slew_step(st.right_rec_applied, st.right_rec_target);
    end

    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_LEFT_REC_ATTEN: next_st.left_rec_target = masked(REG_WDATA, MASK_ATTEN);
        ADDR_RIGHT_REC_ATTEN: next_st.right_rec_target = masked(REG_WDATA, MASK_ATTEN);
        ADDR_LEFT_MIX: next_st.left_mix = masked(REG_WDATA, MASK_LEFT_MIX);
        ADDR_RIGHT_MIX: next_st.right_mix = masked(REG_WDATA, MASK_RIGHT_MIX);
        ADDR_MONO_MIX: next_st.mono_mix = masked(REG_WDATA, MASK_MONO_MIX);
        ADDR_CLAMP: next_st.clamp = masked(REG_WDATA, MASK_CLAMP);
        ADDR_LEFT_LINE: next_st.left_line = masked(REG_WDATA, MASK_LINE);
        ADDR_RIGHT_LINE: next_st.right_line = masked(REG_WDATA, MASK_LINE);
        ADDR_ZC_CTL: next_st.zc_ctl = masked(REG_WDATA, MASK_ZC_CTL);
        default: ;
      endcase
    end

    // Readback shows targets, not the slewing value; unmapped reads zero
    case (REG_ADDR)
      ADDR_LEFT_REC_ATTEN: next_st.rdata = st.left_rec_target;
      ADDR_RIGHT_REC_ATTEN: next_st.rdata = st.right_rec_target;
      ADDR_LEFT_MIX: next_st.rdata = st.left_mix;
      ADDR_RIGHT_MIX: next_st.rdata = st.right_mix;
      ADDR_MONO_MIX: next_st.rdata = st.mono_mix;
      ADDR_CLAMP: next_st.rdata = st.clamp;
      ADDR_LEFT_LINE: next_st.rdata = st.left_line;
      ADDR_RIGHT_LINE: next_st.rdata = st.right_line;
      ADDR_ZC_CTL: next_st.rdata = st.zc_ctl;
      default: next_st.rdata = 8'h00;
    endcase

    if (!RST_N) begin
      next_st = '0;
      next_st.left_rec_target = RST_ATTEN;
      next_st.left_rec_applied = RST_ATTEN;
      next_st.right_rec_target = RST_ATTEN;
      next_st.right_rec_applied = RST_ATTEN;
      next_st.left_mix = RST_MIX;
      next_st.right_mix = RST_MIX;
      next_st.mono_mix = RST_MIX;
      next_st.clamp = RST_CLAMP;
      next_st.left_line = RST_LINE;
      next_st.right_line = RST_LINE;
      next_st.zc_ctl = RST_ZC_CTL;
    end
  end

  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // Shared timer: a change to any one beep gain waits for the same crossing
  beep_gain_updater #(
    .T20_CYC(T20_CYC),
    .T10_CYC(T10_CYC),
    .T5_CYC(T5_CYC),
    .T2P5_CYC(T2P5_CYC)
  ) beep_gains (
    .clk(CLK),
    .rst_n(RST_N),
    .zc_pulse(zc_pulse),
    .zc_enable(st.zc_ctl[ZC_ENABLE_BIT]),
    .timeout_sel(st.zc_ctl[ZC_TIMEOUT_LSB +: 2]),
    .target_left(st.left_mix[STEREO_BEEP_LSB +: 4]),
    .target_right(st.right_mix[STEREO_BEEP_LSB +: 4]),
    .target_mono(st.mono_mix[MONO_BEEP_LSB +: 4]),
    .applied_left(LEFT_BEEP_GAIN),
    .applied_right(RIGHT_BEEP_GAIN),
    .applied_mono(MONO_BEEP_GAIN)
  );

  // Hard mutes come straight from the register bits, no slew
  assign REG_RDATA = st.rdata;
  assign LEFT_REC_ATTEN = st.left_rec_applied;
  assign RIGHT_REC_ATTEN = st.right_rec_applied;
  assign LEFT_DAC_UNMUTE = st.left_mix[LEFT_DAC_UNMUTE_BIT];
  assign RIGHT_DAC_UNMUTE = st.right_mix[RIGHT_DAC_UNMUTE_BIT];
  assign MONO_LEFT_DAC_UNMUTE = st.mono_mix[MONO_LEFT_UNMUTE_BIT];
  assign MONO_RIGHT_DAC_UNMUTE = st.mono_mix[MONO_RIGHT_UNMUTE_BIT];
  assign MONO_LINE_UNMUTE = st.mono_mix[MONO_LINE_UNMUTE_BIT];
  assign CLAMP_DISABLE = st.clamp[CLAMP_DISABLE_BIT];
  assign CLAMP_LOW_POWER = st.clamp[CLAMP_LOW_POWER_BIT];
  assign LEFT_LINE_UNMUTE = st.left_line[LINE_UNMUTE_BIT];
  assign RIGHT_LINE_UNMUTE = st.right_line[LINE_UNMUTE_BIT];

  chk_atten_frame_only: assert property (@(posedge CLK) disable iff (!RST_N)
    ($past(RST_N) && $changed(st.left_rec_applied)) |-> $past(frame_tick))
    else $error("left attenuation moved outside a frame tick");
  chk_atten_one_step: assert property (@(posedge CLK) disable iff (!RST_N)
    (frame_tick && st.right_rec_applied < st.right_rec_target) |=>
      st.right_rec_applied == $past(st.right_rec_applied) + 8'h01)
    else $error("right attenuation did not step by one code");
  chk_atten_reset_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    !$past(RST_N) |-> (st.left_rec_target == 8'h00 && LEFT_REC_ATTEN == 8'h00))
    else $error("left record attenuator not zero after reset");
  chk_dac_mute_now: assert property (@(posedge CLK) disable iff (!RST_N)
    (REG_WR && REG_ADDR == ADDR_LEFT_MIX) |=>
      LEFT_DAC_UNMUTE == $past(REG_WDATA[LEFT_DAC_UNMUTE_BIT]))
    else $error("left DAC mute not applied at write");
  chk_mono_dac_mute: assert property (@(posedge CLK) disable iff (!RST_N)
    (REG_WR && REG_ADDR == ADDR_MONO_MIX) |=>
      (MONO_RIGHT_DAC_UNMUTE == $past(REG_WDATA[MONO_RIGHT_UNMUTE_BIT]) &&
       MONO_LINE_UNMUTE == $past(REG_WDATA[MONO_LINE_UNMUTE_BIT])))
    else $error("mono mixer mutes not applied at write");
  chk_clamp_control: assert property (@(posedge CLK) disable iff (!RST_N)
    !$past(RST_N) |-> (!CLAMP_DISABLE && CLAMP_LOW_POWER))
    else $error("clamp amplifier reset state wrong");
  chk_line_mute_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (REG_WR && REG_ADDR == ADDR_RIGHT_LINE) |=>
      RIGHT_LINE_UNMUTE == $past(REG_WDATA[LINE_UNMUTE_BIT]))
    else $error("right line mute not applied at write");
  chk_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    ($past(RST_N) && $past(REG_ADDR) == ADDR_RIGHT_MIX) |->
      (REG_RDATA & ~MASK_RIGHT_MIX) == 8'h00)
    else $error("reserved bits read back nonzero");
endmodule // codec_gain_mute_control
`default_nettype wire

// ==== sim/host_model.sv ====
// Host side model: register writes and reads, frame and crossing pins
`default_nettype none
module host_model (
  input wire logic CLK,
  input wire logic [7:0] REG_RDATA,
  output logic [15:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic FRAME_SYNC,
  output logic BEEP_ZC
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    REG_ADDR = 16'h0000;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    FRAME_SYNC = 1'b0;
    BEEP_ZC = 1'b0;
  end

  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge CLK);
    #1;
    REG_ADDR = addr;
    REG_WDATA = data;
    REG_WR = 1'b1;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
    // Released data never keeps the last value
    REG_WDATA = ~data;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(posedge CLK);
    #1;
    REG_ADDR = addr;
    @(posedge CLK);
    #1;
    data = REG_RDATA;
  endtask

  // High long enough to pass the two-flop synchroniser
  task automatic frame();
    FRAME_SYNC = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    FRAME_SYNC = 1'b0;
    repeat (4) @(posedge CLK);
    #1;
  endtask

  task automatic zc();
    BEEP_ZC = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    BEEP_ZC = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
  endtask
endmodule // host_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the gain and mute control registers
`default_nettype none
module testbench import gain_mute_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_N, REG_WR, FRAME_SYNC, BEEP_ZC;
  logic [15:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, LEFT_REC_ATTEN, RIGHT_REC_ATTEN, rdv;
  logic LEFT_DAC_UNMUTE, RIGHT_DAC_UNMUTE, MONO_LEFT_DAC_UNMUTE, MONO_RIGHT_DAC_UNMUTE;
  logic MONO_LINE_UNMUTE, CLAMP_DISABLE, CLAMP_LOW_POWER, LEFT_LINE_UNMUTE, RIGHT_LINE_UNMUTE;
  logic [3:0] LEFT_BEEP_GAIN, RIGHT_BEEP_GAIN, MONO_BEEP_GAIN;
  int fail_count = 0;
  int total_checks = 0;
  // Short timeouts keep the run brief: 20, 10, 5, 2.5 ms scaled down
  int tmo [4] = '{40, 20, 10, 5};
  logic [15:0] addrs [9] = '{ADDR_LEFT_REC_ATTEN, ADDR_RIGHT_REC_ATTEN, ADDR_LEFT_MIX,
    ADDR_RIGHT_MIX, ADDR_MONO_MIX, ADDR_CLAMP, ADDR_LEFT_LINE, ADDR_RIGHT_LINE, ADDR_ZC_CTL};
  logic [7:0] masks [9] = '{MASK_ATTEN, MASK_ATTEN, MASK_LEFT_MIX, MASK_RIGHT_MIX,
    MASK_MONO_MIX, MASK_CLAMP, MASK_LINE, MASK_LINE, MASK_ZC_CTL};
  logic [7:0] rsts [9] = '{RST_ATTEN, RST_ATTEN, RST_MIX, RST_MIX, RST_MIX, RST_CLAMP,
    RST_LINE, RST_LINE, RST_ZC_CTL};

  codec_gain_mute_control #(.T20_CYC(40), .T10_CYC(20), .T5_CYC(10), .T2P5_CYC(5)) dut_u (
    .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .FRAME_SYNC(FRAME_SYNC), .BEEP_ZC(BEEP_ZC),
    .LEFT_REC_ATTEN(LEFT_REC_ATTEN), .RIGHT_REC_ATTEN(RIGHT_REC_ATTEN),
    .LEFT_DAC_UNMUTE(LEFT_DAC_UNMUTE), .RIGHT_DAC_UNMUTE(RIGHT_DAC_UNMUTE),
    .MONO_LEFT_DAC_UNMUTE(MONO_LEFT_DAC_UNMUTE), .MONO_RIGHT_DAC_UNMUTE(MONO_RIGHT_DAC_UNMUTE),
    .MONO_LINE_UNMUTE(MONO_LINE_UNMUTE), .LEFT_BEEP_GAIN(LEFT_BEEP_GAIN),
    .RIGHT_BEEP_GAIN(RIGHT_BEEP_GAIN), .MONO_BEEP_GAIN(MONO_BEEP_GAIN),
    .CLAMP_DISABLE(CLAMP_DISABLE), .CLAMP_LOW_POWER(CLAMP_LOW_POWER),
    .LEFT_LINE_UNMUTE(LEFT_LINE_UNMUTE), .RIGHT_LINE_UNMUTE(RIGHT_LINE_UNMUTE));

  host_model host_u (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .FRAME_SYNC(FRAME_SYNC), .BEEP_ZC(BEEP_ZC));

  function automatic logic [8:0] outs();
    return {LEFT_DAC_UNMUTE, RIGHT_DAC_UNMUTE, MONO_LEFT_DAC_UNMUTE, MONO_RIGHT_DAC_UNMUTE,
      MONO_LINE_UNMUTE, CLAMP_DISABLE, CLAMP_LOW_POWER, LEFT_LINE_UNMUTE, RIGHT_LINE_UNMUTE};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d failures=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Whole run is a few hundred cycles
  initial begin
    #200us;
    fail_count++;
    test_done();
  end

  initial begin
    RST_N = 1'b0;
    repeat (4) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    check(outs(), 9'h004);
    check(LEFT_REC_ATTEN, 8'h00);
    for (int i = 0; i < 9; i++) begin
      host_u.rd(addrs[i], rdv);
      check(rdv, rsts[i]);
    end
    host_u.rd(16'h4021, rdv);
    check(rdv, 8'h00);
    // All ones must leave only implemented bits set
    for (int i = 0; i < 9; i++) begin
      host_u.wr(addrs[i], 8'hff);
      host_u.rd(addrs[i], rdv);
      check(rdv, masks[i]);
    end
    host_u.wr(16'h4021, 8'hff);
    check(outs(), 9'h1ff);
    // Clamp goes back to enabled and low power, line outputs back to muted
    for (int i = 0; i < 9; i++) begin
      host_u.wr(addrs[i], rsts[i]);
    end
    repeat (10) @(posedge CLK);
    #1;
    check(outs(), 9'h004);
    host_u.wr(ADDR_LEFT_MIX, 8'h20);
    check(LEFT_DAC_UNMUTE, 1'b1);
    host_u.wr(ADDR_RIGHT_MIX, 8'h40);
    check(RIGHT_DAC_UNMUTE, 1'b1);
    host_u.wr(ADDR_LEFT_REC_ATTEN, 8'h03);
    host_u.wr(ADDR_RIGHT_REC_ATTEN, 8'hff);
    check(LEFT_REC_ATTEN, 8'h00);
    for (int f = 1; f <= 4; f++) begin
      host_u.frame();
      check(LEFT_REC_ATTEN, (f > 3) ? 16'd3 : 16'(f));
      check(RIGHT_REC_ATTEN, 16'(f));
    end
    host_u.wr(ADDR_LEFT_REC_ATTEN, 8'h01);
    for (int f = 1; f <= 2; f++) begin
      host_u.frame();
      check(LEFT_REC_ATTEN, 16'(3 - f));
    end
    // Hard mute acts at write completion, without a frame
    host_u.wr(ADDR_LEFT_MIX, 8'h00);
    check(LEFT_DAC_UNMUTE, 1'b0);
    host_u.wr(ADDR_ZC_CTL, 8'h00);
    // Gain rises one 3 dB step per write
    for (int c = 1; c <= 8; c++) begin
      host_u.wr(ADDR_MONO_MIX, 8'(c << 2));
      @(posedge CLK);
      #1;
      check(MONO_BEEP_GAIN, 16'(c));
    end
    host_u.wr(ADDR_MONO_MIX, 8'h00);
    @(posedge CLK);
    #1;
    check(MONO_BEEP_GAIN, 16'h0);
    host_u.wr(ADDR_ZC_CTL, 8'h01);
    host_u.wr(ADDR_LEFT_MIX, 8'h02);
    host_u.wr(ADDR_RIGHT_MIX, 8'h02);
    host_u.wr(ADDR_MONO_MIX, 8'h04);
    check({LEFT_BEEP_GAIN, RIGHT_BEEP_GAIN, MONO_BEEP_GAIN}, 16'h000);
    host_u.zc();
    check({LEFT_BEEP_GAIN, RIGHT_BEEP_GAIN, MONO_BEEP_GAIN}, 16'h111);
    // No crossing: each timeout code forces the change
    for (int s = 0; s < 4; s++) begin
      host_u.wr(ADDR_ZC_CTL, 8'({s[1:0], 3'b001}));
      host_u.wr(ADDR_LEFT_MIX, 8'((s + 2) << 1));
      repeat (tmo[s] - 3) @(posedge CLK);
      #1;
      check(LEFT_BEEP_GAIN, 16'(s + 1));
      repeat (7) @(posedge CLK);
      #1;
      check(LEFT_BEEP_GAIN, 16'(s + 2));
    end
    test_done();
  end
endmodule // testbench
`default_nettype wire
